// ### rtl/cwk_defines.svh
// Offsets, field positions, reset values and timing figures of the wake and flag block
`ifndef CWK_DEFINES_SVH
`define CWK_DEFINES_SVH

`define CWK_CLK_NS       100
`define CWK_CYC_UP(ns)   (((ns) + `CWK_CLK_NS - 1) / `CWK_CLK_NS)
`define CWK_CYC_DN(ns)   ((ns) / `CWK_CLK_NS)

`define CWK_UNDERVOLTAGE_DETECT_TIME_NS  100000
`define CWK_UNDERVOLTAGE_RECOVERY_TIME_NS  1000000
`define CWK_T_WAKE_NS    50000
`define CWK_T_BUSDOM_NS  5000
`define CWK_T_BUSREC_NS  5000
`define CWK_T_PAT_TO_NS  1000000
`define CWK_T_TXD_TO_NS  2500000
`define CWK_T_BUS_TO_NS  2500000
`define CWK_T_HOLD_NS    50000
`define CWK_BUSF_CYCLES  4

`define CWK_OFS_STATUS   8'h00
`define CWK_OFS_MODE     8'h04
`define CWK_OFS_CTRL     8'h08

`define CWK_ST_SUP_UV    0
`define CWK_ST_BAT_UV    1
`define CWK_ST_PWON      2
`define CWK_ST_WAKE      3
`define CWK_ST_WSRC      4
`define CWK_ST_BUSF      5
`define CWK_ST_LOCF      6
`define CWK_ST_CLAMP     7
`define CWK_ST_TXBLK     8
`define CWK_CTRL_LWAKE   0
`define CWK_CTRL_RWAKE   1
`define CWK_CTRL_RESET   2'h3

`endif

// ### rtl/cwk_pkg.sv
// Types shared by the wake and flag block
package cwk_pkg;

    typedef enum logic [2:0] {
        CWK_NORMAL, CWK_LISTEN, CWK_STANDBY, CWK_GTS, CWK_SLEEP
    } cwk_mode_type;

    typedef enum logic [1:0] {
        CWK_WKP_IDLE, CWK_WKP_GAP, CWK_WKP_DOM2
    } cwk_wkp_type;

    typedef struct packed {
        logic vcc_low;
        logic vio_low;
        logic vbat_low;
        logic overtemp;
        logic bus_short;
        logic txd_rxd_short;
        logic bus_dominant;
    } cwk_sense_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cwk_apb_req_type;

endpackage : cwk_pkg

// ### rtl/cwk_transceiver.sv
// Flag, bus wake and local failure logic of a CAN transceiver
//
// Behaviour
// - Supply low past detect time sets flag
// - Supply undervoltage forces Sleep, inhibit released
// - Wake, power-on, standby rise clear flag
// - Recovery time clears flag, follow pins
// - Battery low: flag, Standby, disengage bus
// - Battery recovery sets power-on, wake flags
// - Power-on flag shown in Listen-only
// - Local wake pin sets flag in low power
// - Wake drives fault and receive low
// - Wake set at power-on, cleared later
// - Remote wake needs dominant-recessive-dominant
// - Short intervals ignored in pattern
// - Pattern timeout resets the detector
// - Receive high until wake event
// - Normal, timeout or undervoltage suppress wake
// - Wake source flag set, shown, cleared
// - Four shorted cycles set bus failure
// - Local failure flag set and cleared
// - Transmit dominant timeout blocks transmitter
// - Transmit-receive short blocks transmitter
// - Bus clamp reported, not latched
// - Overtemperature blocks transmitter, sets flag
// - Fault output low means flag set
// - Wake source then bus failure shown
// - Go-to-Sleep hold time, abort on change
`include "cwk_defines.svh"

module cwk_transceiver
    import cwk_pkg::*;
#(
    parameter int unsigned CW         = 16,
    parameter int unsigned DET_UV_CYC = `CWK_CYC_UP(`CWK_UNDERVOLTAGE_DETECT_TIME_NS),
    parameter int unsigned REC_UV_CYC = `CWK_CYC_UP(`CWK_UNDERVOLTAGE_RECOVERY_TIME_NS),
    parameter int unsigned WAKE_CYC   = `CWK_CYC_UP(`CWK_T_WAKE_NS),
    parameter int unsigned BDOM_CYC   = `CWK_CYC_UP(`CWK_T_BUSDOM_NS),
    parameter int unsigned BREC_CYC   = `CWK_CYC_UP(`CWK_T_BUSREC_NS),
    parameter int unsigned PAT_TO_CYC = `CWK_CYC_DN(`CWK_T_PAT_TO_NS),
    parameter int unsigned TXD_TO_CYC = `CWK_CYC_UP(`CWK_T_TXD_TO_NS),
    parameter int unsigned BUS_TO_CYC = `CWK_CYC_UP(`CWK_T_BUS_TO_NS),
    parameter int unsigned HOLD_CYC   = `CWK_CYC_UP(`CWK_T_HOLD_NS)
) (
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire cwk_apb_req_type apb_req,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire cwk_sense_type   sense,
    input  wire logic            txd,
    input  wire logic            standby_control_n,
    input  wire logic            mode_select,
    input  wire logic            wake_pin,
    output logic                 rxd,
    output logic                 fault_n,
    output logic                 regulator_inhibit_output,
    output logic                 split_enable,
    output logic                 transmit_enable,
    output logic                 bus_bias_enable,
    output cwk_mode_type         mode
);

    localparam logic [CW-1:0] DET_C    = CW'(DET_UV_CYC);
    localparam logic [CW-1:0] REC_C    = CW'(REC_UV_CYC);
    localparam logic [CW-1:0] WAKE_M1  = CW'(WAKE_CYC - 1);
    localparam logic [CW-1:0] BDOM_M1  = CW'(BDOM_CYC - 1);
    localparam logic [CW-1:0] BREC_M1  = CW'(BREC_CYC - 1);
    localparam logic [CW-1:0] PAT_C    = CW'(PAT_TO_CYC);
    localparam logic [CW-1:0] TXD_C    = CW'(TXD_TO_CYC);
    localparam logic [CW-1:0] BUS_M1   = CW'(BUS_TO_CYC - 1);
    localparam logic [CW-1:0] HOLD_C   = CW'(HOLD_CYC);
    localparam logic [2:0]    BUSF_M1  = 3'(`CWK_BUSF_CYCLES - 1);
    localparam logic [2:0]    BUSF_N   = 3'(`CWK_BUSF_CYCLES);
    localparam int            NS       = $bits(cwk_sense_type) + 4;

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        return (&v) ? v : v + CW'(1);
    endfunction : sat_inc

    function automatic logic is_low_power(input cwk_mode_type m);
        return (m == CWK_STANDBY) || (m == CWK_GTS) || (m == CWK_SLEEP);
    endfunction : is_low_power

    function automatic cwk_mode_type pin_mode(input logic stbn, input logic en, input logic wk);
        if (stbn) begin
            return en ? CWK_NORMAL : CWK_LISTEN;
        end
        return (en && !wk) ? CWK_GTS : CWK_STANDBY;
    endfunction : pin_mode

    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        case (a)
            `CWK_OFS_STATUS: return 2'h1;
            `CWK_OFS_MODE:   return 2'h2;
            `CWK_OFS_CTRL:   return 2'h3;
            default:         return 2'h0;
        endcase
    endfunction : reg_sel

    // Two-stage synchronisers for every comparator and pin input
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;

    assign raw = {sense, txd, standby_control_n, mode_select, wake_pin};

    for (genvar i = 0; i < NS; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (rst) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= raw[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end

    cwk_sense_type ss;
    logic          txd_s;
    logic          stbn_s;
    logic          en_s;
    logic          wpin_s;

    assign {ss, txd_s, stbn_s, en_s, wpin_s} = s2_q;

    cwk_mode_type mode_q;
    cwk_mode_type mode_d;
    cwk_mode_type prev_mode_q;
    cwk_wkp_type  wkp_q;
    logic         sup_uv_q;
    logic         bat_uv_q;
    logic         pwon_q;
    logic         wake_q;
    logic         wsrc_q;
    logic         busf_q;
    logic         locf_q;
    logic         clamp_q;
    logic         tx_block_q;
    logic         from_norm_q;
    logic         uv_sleep_q;
    logic         stbn_p_q;
    logic         txd_p_q;
    logic         wlvl_q;
    logic         winit_q;
    logic         shorted_q;
    logic [1:0]   ctrl_q;
    logic [2:0]   edg_q;
    logic [2:0]   busf_cnt_q;
    logic [CW-1:0] det_q;
    logic [CW-1:0] rec_q;
    logic [CW-1:0] wcnt_q;
    logic [CW-1:0] dom_q;
    logic [CW-1:0] rrun_q;
    logic [CW-1:0] pat_q;
    logic [CW-1:0] txdc_q;
    logic [CW-1:0] hold_q;

    logic enter_norm;
    logic leave_norm;
    logic act_nl;
    logic uv_low;
    logic sup_uv_set;
    logic uv_clr;
    logic rec_done;
    logic pwon_set;
    logic stbn_rise;
    logic txd_rise;
    logic local_evt;
    logic remote_evt;
    logic pat_ok;
    logic wake_set;
    logic busf_set;
    logic loc_set;
    logic loc_clr;
    logic sup_ok;

    assign enter_norm = (mode_q == CWK_NORMAL) && (prev_mode_q != CWK_NORMAL);
    assign leave_norm = (prev_mode_q == CWK_NORMAL) && (mode_q != CWK_NORMAL);
    assign act_nl     = (mode_q == CWK_NORMAL) || (mode_q == CWK_LISTEN);
    assign stbn_rise  = stbn_s && !stbn_p_q;
    assign txd_rise   = txd_s && !txd_p_q;
    assign sup_ok     = !ss.vio_low && !ss.vbat_low;

    // Supply undervoltage timers and flag
    assign uv_low     = ss.vcc_low || ss.vio_low;
    assign sup_uv_set = !sup_uv_q && (det_q >= DET_C);
    assign pwon_set   = bat_uv_q && !ss.vbat_low;
    assign uv_clr     = wake_set || pwon_set || stbn_rise;
    assign rec_done   = sup_uv_q && (rec_q >= REC_C);

    always_ff @(posedge clock) begin
        if (rst || uv_clr) begin
            det_q <= '0;
            rec_q <= '0;
        end else begin
            det_q <= uv_low ? sat_inc(det_q) : '0;
            rec_q <= uv_low ? '0 : sat_inc(rec_q);
        end
    end

    // A fresh detection wins over a clear arriving in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            sup_uv_q <= 1'b0;
        end else if (sup_uv_set) begin
            sup_uv_q <= 1'b1;
        end else if (uv_clr || rec_done) begin
            sup_uv_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bat_uv_q <= 1'b0;
            pwon_q   <= 1'b1;
        end else begin
            bat_uv_q <= ss.vbat_low;
            if (pwon_set) begin
                pwon_q <= 1'b1;
            end else if (enter_norm) begin
                pwon_q <= 1'b0;
            end
        end
    end

    // Operating mode
    always_comb begin
        cwk_mode_type pm;
        pm     = pin_mode(stbn_s, en_s, wake_q);
        mode_d = pm;
        if (sup_uv_q) begin
            mode_d = CWK_SLEEP;
        end else if (bat_uv_q) begin
            mode_d = CWK_STANDBY;
        end else begin
            case (mode_q)
                CWK_SLEEP: begin
                    if (!(stbn_s || wake_q || uv_sleep_q)) begin
                        mode_d = CWK_SLEEP;
                    end
                end
                CWK_GTS: begin
                    if (pm == CWK_GTS && hold_q >= HOLD_C) begin
                        mode_d = CWK_SLEEP;
                    end
                end
                default: mode_d = pm;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q      <= CWK_STANDBY;
            prev_mode_q <= CWK_STANDBY;
            hold_q      <= '0;
            uv_sleep_q  <= 1'b0;
            from_norm_q <= 1'b0;
        end else begin
            mode_q      <= mode_d;
            prev_mode_q <= mode_q;
            hold_q      <= (mode_q == CWK_GTS && mode_d == CWK_GTS) ? sat_inc(hold_q) : '0;
            uv_sleep_q  <= sup_uv_q || (uv_sleep_q && mode_q == CWK_SLEEP);
            if (mode_q == CWK_NORMAL) begin
                from_norm_q <= 1'b1;
            end else if (is_low_power(mode_q)) begin
                from_norm_q <= 1'b0;
            end
        end
    end

    // Local wake: a new pin level must hold for the filter time
    assign local_evt = winit_q && (wpin_s != wlvl_q) && (wcnt_q >= WAKE_M1)
                       && is_low_power(mode_q) && ctrl_q[`CWK_CTRL_LWAKE];

    always_ff @(posedge clock) begin
        if (rst) begin
            winit_q <= 1'b0;
            wlvl_q  <= 1'b0;
            wcnt_q  <= '0;
        end else if (!winit_q) begin
            winit_q <= 1'b1;
            wlvl_q  <= wpin_s;
        end else if (wpin_s == wlvl_q) begin
            wcnt_q <= '0;
        end else if (wcnt_q >= WAKE_M1) begin
            wlvl_q <= wpin_s;
            wcnt_q <= '0;
        end else begin
            wcnt_q <= sat_inc(wcnt_q);
        end
    end

    // Bus run lengths shared by the wake pattern and the clamp timeout
    always_ff @(posedge clock) begin
        if (rst) begin
            dom_q  <= '0;
            rrun_q <= '0;
        end else begin
            dom_q  <= ss.bus_dominant ? sat_inc(dom_q) : '0;
            rrun_q <= ss.bus_dominant ? '0 : sat_inc(rrun_q);
        end
    end

    // Glitches never reach a phase threshold, so they cannot advance the pattern
    assign pat_ok     = is_low_power(mode_q) && !sup_uv_q && !sup_uv_set
                        && ctrl_q[`CWK_CTRL_RWAKE] && (pat_q < PAT_C);
    assign remote_evt = pat_ok && (wkp_q == CWK_WKP_DOM2)
                        && ss.bus_dominant && (dom_q >= BDOM_M1);

    always_ff @(posedge clock) begin
        if (rst) begin
            wkp_q <= CWK_WKP_IDLE;
            pat_q <= '0;
        end else if (!pat_ok) begin
            wkp_q <= CWK_WKP_IDLE;
            pat_q <= '0;
        end else begin
            pat_q <= (wkp_q == CWK_WKP_IDLE) ? '0 : sat_inc(pat_q);
            case (wkp_q)
                CWK_WKP_IDLE: begin
                    if (ss.bus_dominant && dom_q >= BDOM_M1) begin
                        wkp_q <= CWK_WKP_GAP;
                    end
                end
                CWK_WKP_GAP: begin
                    if (!ss.bus_dominant && rrun_q >= BREC_M1) begin
                        wkp_q <= CWK_WKP_DOM2;
                    end
                end
                CWK_WKP_DOM2: begin
                    if (remote_evt) begin
                        wkp_q <= CWK_WKP_IDLE;
                    end
                end
                default: wkp_q <= CWK_WKP_IDLE;
            endcase
        end
    end

    // Wake and wake-source flags
    assign wake_set = local_evt || remote_evt || pwon_set;

    always_ff @(posedge clock) begin
        if (rst) begin
            wake_q <= 1'b1;
            wsrc_q <= 1'b1;
        end else begin
            if (wake_set) begin
                wake_q <= 1'b1;
            end else if (sup_uv_set || enter_norm) begin
                wake_q <= 1'b0;
            end
            if (local_evt || pwon_set) begin
                wsrc_q <= 1'b1;
            end else if (leave_norm) begin
                wsrc_q <= 1'b0;
            end
        end
    end

    // Bus failure: consecutive dominant-recessive cycles with a short seen
    assign busf_set = (mode_q == CWK_NORMAL) && txd_rise
                      && (shorted_q || ss.bus_short) && (busf_cnt_q == BUSF_M1);

    always_ff @(posedge clock) begin
        if (rst) begin
            shorted_q  <= 1'b0;
            busf_cnt_q <= '0;
            busf_q     <= 1'b0;
            txd_p_q    <= 1'b1;
            edg_q      <= '0;
        end else begin
            txd_p_q <= txd_s;
            if (mode_q != CWK_NORMAL || txd_rise) begin
                shorted_q <= 1'b0;
            end else if (!txd_s && ss.bus_short) begin
                shorted_q <= 1'b1;
            end
            if (mode_q != CWK_NORMAL || busf_set) begin
                busf_cnt_q <= '0;
            end else if (txd_rise) begin
                busf_cnt_q <= (shorted_q || ss.bus_short) ? busf_cnt_q + 3'h1 : '0;
            end
            if (busf_set) begin
                busf_q <= 1'b1;
            end else if (enter_norm || pwon_set) begin
                busf_q <= 1'b0;
            end
            if (enter_norm) begin
                edg_q <= '0;
            end else if (mode_q == CWK_NORMAL && txd_rise && edg_q < BUSF_N) begin
                edg_q <= edg_q + 3'h1;
            end
        end
    end

    // Local failures
    assign loc_set = act_nl && ((txdc_q >= TXD_C) || ss.txd_rxd_short || ss.overtemp);
    assign loc_clr = enter_norm || pwon_set
                     || (ss.bus_dominant && txd_s && !ss.overtemp && !ss.txd_rxd_short);

    always_ff @(posedge clock) begin
        if (rst) begin
            txdc_q     <= '0;
            locf_q     <= 1'b0;
            tx_block_q <= 1'b0;
            clamp_q    <= 1'b0;
        end else begin
            txdc_q  <= (mode_q == CWK_NORMAL && !txd_s) ? sat_inc(txdc_q) : '0;
            clamp_q <= act_nl && ss.bus_dominant && (dom_q >= BUS_M1);
            if (loc_set) begin
                locf_q     <= 1'b1;
                tx_block_q <= 1'b1;
            end else if (loc_clr) begin
                locf_q     <= 1'b0;
                tx_block_q <= 1'b0;
            end
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge clock) begin
        if (rst) begin
            rxd                      <= 1'b1;
            fault_n                  <= 1'b1;
            regulator_inhibit_output <= 1'b1;
            split_enable             <= 1'b0;
            transmit_enable          <= 1'b0;
            bus_bias_enable          <= 1'b0;
            stbn_p_q                 <= 1'b0;
        end else begin
            stbn_p_q                 <= stbn_s;
            regulator_inhibit_output <= (mode_d != CWK_SLEEP);
            split_enable             <= (mode_d == CWK_NORMAL) || (mode_d == CWK_LISTEN);
            bus_bias_enable          <= !ss.vbat_low;
            transmit_enable          <= (mode_d == CWK_NORMAL) && !tx_block_q
                                        && !loc_set && !ss.vbat_low;
            if (is_low_power(mode_q)) begin
                rxd     <= !(wake_q && sup_ok);
                fault_n <= !(wake_q && sup_ok);
            end else begin
                rxd <= !ss.bus_dominant;
                case (mode_q)
                    CWK_NORMAL: fault_n <= (edg_q < BUSF_N) ? !wsrc_q : !busf_q;
                    CWK_LISTEN: fault_n <= from_norm_q ? !(locf_q || clamp_q) : !pwon_q;
                    default:    fault_n <= 1'b1;
                endcase
            end
        end
    end

    assign mode = mode_q;

    // APB slave with no wait states: the answer is prepared in the setup cycle
    logic [31:0] status_w;
    logic [31:0] rdata_w;
    logic [1:0]  sel_w;

    assign sel_w = reg_sel(apb_req.paddr);

    always_comb begin
        status_w                  = '0;
        status_w[`CWK_ST_SUP_UV]  = sup_uv_q;
        status_w[`CWK_ST_BAT_UV]  = bat_uv_q;
        status_w[`CWK_ST_PWON]    = pwon_q;
        status_w[`CWK_ST_WAKE]    = wake_q;
        status_w[`CWK_ST_WSRC]    = wsrc_q;
        status_w[`CWK_ST_BUSF]    = busf_q;
        status_w[`CWK_ST_LOCF]    = locf_q;
        status_w[`CWK_ST_CLAMP]   = clamp_q;
        status_w[`CWK_ST_TXBLK]   = tx_block_q;
        case (sel_w)
            2'h1:    rdata_w = status_w;
            2'h2:    rdata_w = {29'h0, mode_q};
            2'h3:    rdata_w = {30'h0, ctrl_q};
            default: rdata_w = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (apb_req.psel && !apb_req.penable) begin
            pready  <= 1'b1;
            pslverr <= (sel_w == 2'h0);
            prdata  <= apb_req.pwrite ? '0 : rdata_w;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= `CWK_CTRL_RESET;
        end else if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite && sel_w == 2'h3) begin
            ctrl_q <= apb_req.pwdata[1:0];
        end
    end

endmodule : cwk_transceiver

// ### testbench/cwk_ctl_model.sv
// Protocol controller model driving the mode and transmit pins
module cwk_ctl_model (
    input  wire logic clock,
    output logic      txd,
    output logic      standby_control_n,
    output logic      mode_select
);
    timeunit 1ns;
    timeprecision 1ns;
    // Fault output is only trusted 8 us after a mode change
    localparam int SETTLE = 80;
    initial begin
        txd = 1'b1;
        standby_control_n = 1'b0;
        mode_select = 1'b0;
    end
    task set_mode(input logic stb, input logic en);
        standby_control_n <= stb;
        mode_select <= en;
        repeat (SETTLE) @(posedge clock);
    endtask : set_mode
    task tx(input int n, input int len);
        repeat (n) begin
            txd <= 1'b0;
            repeat (len) @(posedge clock);
            txd <= 1'b1;
            repeat (len) @(posedge clock);
        end
    endtask : tx
endmodule : cwk_ctl_model

// ### testbench/cwk_transceiver_properties.sv
// Port checker for the flag and wake block
module cwk_checker
    import cwk_pkg::*;
#(
    parameter int unsigned TXD_TO_CYC = 20,
    parameter int unsigned DET_UV_CYC = 4
) (
    input wire logic            clock,
    input wire logic            rst,
    input wire cwk_apb_req_type apb_req,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire cwk_sense_type   sense,
    input wire logic            txd,
    input wire logic            regulator_inhibit_output,
    input wire logic            split_enable,
    input wire logic            transmit_enable,
    input wire logic            bus_bias_enable,
    input wire cwk_mode_type    mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [7:0] txd_low_q;
    logic [7:0] vcc_low_q;
    // Counters saturate so a long hold cannot wrap and re-arm a check
    always_ff @(posedge clock) begin
        if (rst || txd || mode != CWK_NORMAL) txd_low_q <= 8'h00;
        else if (txd_low_q != 8'hFF) txd_low_q <= txd_low_q + 8'h01;
    end
    always_ff @(posedge clock) begin
        if (rst || !sense.vcc_low) vcc_low_q <= 8'h00;
        else if (vcc_low_q != 8'hFF) vcc_low_q <= vcc_low_q + 8'h01;
    end
    sequence apb_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence sleep_soon;
        ##[1:4] mode == CWK_SLEEP;
    endsequence
    pready_a: assert property (apb_setup |=> pready) else $error("no access cycle");
    pready_once_a: assert property (pready |=> !pready) else $error("pready too long");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
    split_mode_a: assert property (split_enable == (mode inside {CWK_NORMAL, CWK_LISTEN}))
        else $error("split enable wrong");
    txen_mode_a: assert property (transmit_enable |-> mode == CWK_NORMAL) else $error("tx outside normal");
    inhibit_sleep_a: assert property (!regulator_inhibit_output |-> mode == CWK_SLEEP)
        else $error("inhibit off outside sleep");
    bias_off_a: assert property (sense.vbat_low [*6] |-> !bus_bias_enable) else $error("bias on");
    txd_block_a: assert property (txd_low_q == TXD_TO_CYC + 8 |-> !transmit_enable)
        else $error("tx not blocked");
    uv_sleep_a: assert property (vcc_low_q == DET_UV_CYC + 4 |-> sleep_soon) else $error("no sleep");
endmodule : cwk_checker

bind cwk_transceiver cwk_checker #(
    .TXD_TO_CYC(TXD_TO_CYC),
    .DET_UV_CYC(DET_UV_CYC)
) u_checker (
    .clock, .rst, .apb_req, .prdata, .pready, .pslverr, .sense, .txd, .regulator_inhibit_output,
    .split_enable, .transmit_enable, .bus_bias_enable, .mode
);

// ### testbench/tb_top.sv
// Self-checking bench for the flag and wake block
module tb_top
    import cwk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clock = 1'b0;
    logic            rst = 1'b1;
    logic            wake_pin = 1'b0;
    cwk_apb_req_type apb_req = '0;
    cwk_sense_type   sense = '0;
    logic [31:0]     prdata, rd;
    logic            pready, pslverr, perr, rxd, fault_n, txd, standby_control_n, mode_select;
    logic            regulator_inhibit_output, split_enable, transmit_enable, bus_bias_enable;
    cwk_mode_type    mode;
    int              bad_count = 0;
    int              num_checks = 0;

    always #50 clock = ~clock;

    cwk_ctl_model ctl (.clock, .txd, .standby_control_n, .mode_select);
    cwk_transceiver #(.DET_UV_CYC(4), .REC_UV_CYC(8), .WAKE_CYC(4), .BDOM_CYC(3), .BREC_CYC(3),
        .PAT_TO_CYC(60), .TXD_TO_CYC(100), .HOLD_CYC(6)) DUT (
        .clock, .rst, .apb_req, .prdata, .pready, .pslverr, .sense, .txd, .standby_control_n,
        .mode_select, .wake_pin, .rxd, .fault_n, .regulator_inhibit_output, .split_enable,
        .transmit_enable, .bus_bias_enable, .mode);

    task complete_run();
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            complete_run();
        end
        rd = prdata;
        perr = pslverr;
        apb_req <= '0;
        @(posedge clock);
    endtask : apb
    task bus(input logic v, input int n);
        sense.bus_dominant <= v;
        cyc(n);
    endtask : bus

    task s_reset();
        chk("rxd", 32'h0, rxd);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", 32'h1C, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("slverr", 32'h1, perr);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(1'b1, 8'h08, 32'h3);
    endtask : s_reset
    task s_normal();
        ctl.set_mode(1'b1, 1'b1);
        chk("fault", 32'h0, fault_n);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", 32'h10, rd);
        ctl.tx(4, 40);
        chk("fault", 32'h1, fault_n);
        sense.bus_short <= 1'b1;
        ctl.tx(4, 40);
        sense.bus_short <= 1'b0;
        chk("fault", 32'h0, fault_n);
    endtask : s_normal
    task s_txd();
        ctl.tx(1, 115);
        chk("txen", 32'h0, transmit_enable);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", 32'h170, rd);
        ctl.set_mode(1'b1, 1'b0);
        chk("fault", 32'h0, fault_n);
        ctl.set_mode(1'b1, 1'b1);
        chk("txen", 32'h1, transmit_enable);
    endtask : s_txd
    task s_local();
        sense.txd_rxd_short <= 1'b1;
        cyc(6);
        chk("txen", 32'h0, transmit_enable);
        sense.txd_rxd_short <= 1'b0;
        bus(1'b1, 6);
        bus(1'b0, 6);
        chk("txen", 32'h1, transmit_enable);
        sense.overtemp <= 1'b1;
        cyc(6);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", 32'h140, rd);
        sense.overtemp <= 1'b0;
        bus(1'b1, 6);
        bus(1'b0, 6);
        chk("txen", 32'h1, transmit_enable);
    endtask : s_local
    task s_lwake();
        ctl.set_mode(1'b0, 1'b0);
        chk("rxd", 32'h1, rxd);
        wake_pin <= 1'b1;
        cyc(12);
        chk("rxd", 32'h0, rxd);
        chk("fault", 32'h0, fault_n);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", 32'h18, rd);
    endtask : s_lwake
    task s_rwake();
        ctl.set_mode(1'b1, 1'b1);
        ctl.set_mode(1'b0, 1'b1);
        chk("mode", CWK_SLEEP, mode);
        bus(1'b1, 6);
        bus(1'b0, 70);
        bus(1'b1, 6);
        bus(1'b0, 6);
        chk("rxd", 32'h1, rxd);
        bus(1'b1, 6);
        bus(1'b0, 6);
        chk("rxd", 32'h0, rxd);
        ctl.set_mode(1'b0, 1'b0);
    endtask : s_rwake
    task s_supply();
        sense.vcc_low <= 1'b1;
        cyc(16);
        chk("mode", CWK_SLEEP, mode);
        chk("inhibit", 32'h0, regulator_inhibit_output);
        sense.vcc_low <= 1'b0;
        cyc(16);
        chk("mode", CWK_STANDBY, mode);
        sense.vbat_low <= 1'b1;
        cyc(8);
        chk("bias", 32'h0, bus_bias_enable);
        sense.vbat_low <= 1'b0;
        cyc(8);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", 32'h7, rd[4:2]);
        sense.vio_low <= 1'b1;
        cyc(16);
        chk("mode", CWK_SLEEP, mode);
    endtask : s_supply

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        cyc(3);
        s_reset();
        s_normal();
        s_txd();
        s_local();
        s_lwake();
        s_rwake();
        s_supply();
        complete_run();
    end
endmodule : tb_top
